// ==== src/bcf_an_end.sv ====
// Purpose: Access end of the bearer control link, fault notification
// Assumes: 10 MHz mclk_i, exchange end on the same clock
// Notes: Sends fault and protocol error frames, validates all input
//
// What this block does
// - Fault request sends fault, starts timer
// - Exchange indicates fault and returns acknowledge
// - Matching acknowledge stops timer, confirms, operational
// - First expiry resends fault, restarts timer
// - Second expiry abandons, signals fault error
// - Under four octets: discard, indicate, no reply
// - Beyond two optionals truncate as repeated
// - Checks in precedence; only survivors dispatched
// - Bad discriminator discarded; access end replies
// - Unknown type discarded; access end replies
// - Lower identifier than predecessor is out-of-sequence
// - Out-of-sequence dropped; mandatory loss then missing
// - Repeated mandatory discards whole message
// - Repeated optional removed, processing continues
// - Missing mandatory discards; first missing reported
// - Unrecognised removed; first one reported
// - Header discriminator, reference, type parsed first
// - Discard leaves fault procedure state untouched
// - Timers within ten percent of setting
`timescale 1ns/100ps
module bcf_an_end #(
  parameter int TICK_CYC = bcf_pkg::BCF_TICK_CYC,
  parameter int T5_TICKS = bcf_pkg::BCF_T5_TICKS
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Link toward the exchange
  bcf_link_if.an lnk,
  // Fault request from management
  input wire logic flt_req_i,
  input wire logic [7:0] flt_ts_i,
  input wire logic [7:0] flt_port_i,
  // Management primitives
  output logic mgmt_bearer_valid_o,
  output bcf_pkg::bcf_prim_t mgmt_bearer_primitive_o,
  output logic flt_active_o,
  // Protocol error report
  output logic perr_o,
  output bcf_pkg::bcf_cause_t perr_cause_o,
  output logic [7:0] perr_diag_o,
  // Dispatch of accepted messages
  output logic rx_ok_o,
  output logic [7:0] rx_type_o,
  output logic [15:0] rx_ref_o
);
  import bcf_pkg::*;

  localparam int PW = $clog2(TICK_CYC);

  typedef enum logic {ST_OPER, ST_REPORT} bcf_an_state_t;

  bcf_an_state_t st;
  logic retried;
  logic [15:0] flt_ref, pe_ref;
  logic [7:0] flt_ts, flt_port, pe_diag;
  bcf_cause_t pe_cause;
  logic [PW-1:0] pre;
  logic [7:0] tcnt;
  logic tick, start, ack_hit, expire, resend, abandon, flt_fire, pe_fire;
  logic flt_pend, pe_pend, go_flt, go_pe, busy, kind_flt;
  logic [3:0] idx;
  logic [7:0] oct;
  logic tx_v, tx_last;
  logic [7:0] tx_d;
  logic ck_ok, ck_err, ck_disc;
  bcf_cause_t ck_cause;
  logic [7:0] ck_diag, ck_type;
  logic [15:0] ck_ref;

  bcf_msg_check u_check (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .rx_valid_i(lnk.l2a_valid),
    .rx_data_i(lnk.l2a_data),
    .rx_last_i(lnk.l2a_last),
    .ok_o(ck_ok),
    .err_o(ck_err),
    .disc_o(ck_disc),
    .cause_o(ck_cause),
    .diag_o(ck_diag),
    .type_o(ck_type),
    .ref_o(ck_ref),
    .val_o()
  );

  assign perr_o = ck_err;
  assign perr_cause_o = ck_cause;
  assign perr_diag_o = ck_diag;
  assign rx_ok_o = ck_ok;
  assign rx_type_o = ck_type;
  assign rx_ref_o = ck_ref;
  assign lnk.a2l_valid = tx_v;
  assign lnk.a2l_data = tx_d;
  assign lnk.a2l_last = tx_last;

  // Procedure events; an acknowledge beats an expiry in the same cycle
  assign tick = pre == PW'(TICK_CYC - 1);
  assign start = st == ST_OPER && flt_req_i;
  assign ack_hit = st == ST_REPORT && ck_ok && ck_type == BCF_MT_FAULT_ACK
                   && ck_ref == flt_ref;
  assign expire = st == ST_REPORT && tick && tcnt == 8'(T5_TICKS - 1) && !ack_hit;
  assign resend = expire && !retried;
  assign abandon = expire && retried;
  assign flt_fire = start || resend;
  assign pe_fire = ck_err && ck_cause != BCF_C_SHORT;

  // Fault procedure state
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st <= ST_OPER;
      retried <= 1'b0;
      flt_active_o <= 1'b0;
      flt_ref <= BCF_REF_RST;
      flt_ts <= 8'h00;
      flt_port <= 8'h00;
    end else if (start) begin
      st <= ST_REPORT;
      retried <= 1'b0;
      flt_active_o <= 1'b1;
      flt_ref <= flt_ref + 16'h0001;
      flt_ts <= flt_ts_i;
      flt_port <= flt_port_i;
    end else if (ack_hit || abandon) begin
      st <= ST_OPER;
      flt_active_o <= 1'b0;
    end else if (resend) begin
      retried <= 1'b1;
    end
  end

  // Prescaler restarts with the timer so the first tick is never short
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || flt_fire) begin
      pre <= '0;
      tcnt <= 8'h00;
    end else begin
      pre <= tick ? '0 : pre + 1'b1;
      if (tick) begin
        tcnt <= tcnt + 8'h01;
      end
    end
  end

  // Management primitives
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mgmt_bearer_valid_o <= 1'b0;
      mgmt_bearer_primitive_o <= BCF_P_NONE;
    end else begin
      mgmt_bearer_valid_o <= ack_hit || abandon;
      if (ack_hit) begin
        mgmt_bearer_primitive_o <= BCF_P_FAULT_CFM;
      end else if (abandon) begin
        mgmt_bearer_primitive_o <= BCF_P_FAULT_ERR;
      end else begin
        mgmt_bearer_primitive_o <= BCF_P_NONE;
      end
    end
  end

  // Pending frames; a new request wins over the clear of the old one
  assign go_flt = !busy && !tx_v && flt_pend;
  assign go_pe = !busy && !tx_v && pe_pend && !flt_pend;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      flt_pend <= 1'b0;
      pe_pend <= 1'b0;
      pe_ref <= 16'h0000;
      pe_cause <= BCF_C_NONE;
      pe_diag <= 8'h00;
    end else begin
      flt_pend <= flt_fire || (flt_pend && !go_flt);
      pe_pend <= pe_fire || (pe_pend && !go_pe);
      // Only the newest error is kept while one waits
      if (pe_fire) begin
        pe_ref <= ck_ref;
        pe_cause <= ck_cause;
        pe_diag <= ck_diag;
      end
    end
  end

  // Frame octets: header, then two one-octet elements
  always_comb begin
    case (idx)
      4'h0: oct = BCF_PD;
      4'h1: oct = kind_flt ? flt_ref[15:8] : pe_ref[15:8];
      4'h2: oct = kind_flt ? flt_ref[7:0] : pe_ref[7:0];
      4'h3: oct = kind_flt ? BCF_MT_FAULT : BCF_MT_PERR;
      4'h4: oct = kind_flt ? BCF_IE_TS : BCF_IE_CAUSE;
      4'h6: oct = kind_flt ? flt_ts : 8'(pe_cause);
      4'h7: oct = kind_flt ? BCF_IE_PORT : BCF_IE_DIAG;
      4'h9: oct = kind_flt ? flt_port : pe_diag;
      default: oct = BCF_IE_LEN1;
    endcase
  end

  // Serialiser; idle cycle after each frame keeps the far checker in step
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      busy <= 1'b0;
      kind_flt <= 1'b0;
      idx <= 4'h0;
      tx_v <= 1'b0;
      tx_d <= 8'h00;
      tx_last <= 1'b0;
    end else if (busy) begin
      tx_v <= 1'b1;
      tx_d <= oct;
      tx_last <= idx == BCF_TX_LEN - 4'h1;
      idx <= idx + 4'h1;
      if (idx == BCF_TX_LEN - 4'h1) begin
        busy <= 1'b0;
      end
    end else begin
      tx_v <= 1'b0;
      tx_last <= 1'b0;
      idx <= 4'h0;
      if (go_flt || go_pe) begin
        busy <= 1'b1;
        kind_flt <= go_flt;
      end
    end
  end

endmodule : bcf_an_end

// ==== src/bcf_le_end.sv ====
// Purpose: Exchange end of the bearer control link, fault acknowledge
// Assumes: 10 MHz mclk_i, access end on the same clock
// Notes: Never answers a bad message, only indicates it
`timescale 1ns/100ps
module bcf_le_end (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Link toward the access end
  bcf_link_if.le lnk,
  // Management primitives
  output logic mgmt_bearer_valid_o,
  output bcf_pkg::bcf_prim_t mgmt_bearer_primitive_o,
  output logic [7:0] mgmt_ts_o,
  output logic [7:0] mgmt_port_o,
  // Protocol error report
  output logic perr_o,
  output bcf_pkg::bcf_cause_t perr_cause_o,
  output logic [7:0] perr_diag_o,
  // Dispatch of accepted messages
  output logic rx_ok_o,
  output logic [7:0] rx_type_o,
  output logic [15:0] rx_ref_o
);
  import bcf_pkg::*;

  logic ck_ok, ck_err, ck_disc, ack_fire, ack_pend, go, busy;
  bcf_cause_t ck_cause;
  logic [7:0] ck_diag, ck_type, oct;
  logic [15:0] ck_ref, ack_ref;
  logic [7:0][7:0] ck_val;
  logic [1:0] idx;
  logic tx_v, tx_last;
  logic [7:0] tx_d;

  bcf_msg_check u_check (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .rx_valid_i(lnk.a2l_valid),
    .rx_data_i(lnk.a2l_data),
    .rx_last_i(lnk.a2l_last),
    .ok_o(ck_ok),
    .err_o(ck_err),
    .disc_o(ck_disc),
    .cause_o(ck_cause),
    .diag_o(ck_diag),
    .type_o(ck_type),
    .ref_o(ck_ref),
    .val_o(ck_val)
  );

  assign perr_o = ck_err;
  assign perr_cause_o = ck_cause;
  assign perr_diag_o = ck_diag;
  assign rx_ok_o = ck_ok;
  assign rx_type_o = ck_type;
  assign rx_ref_o = ck_ref;
  assign lnk.l2a_valid = tx_v;
  assign lnk.l2a_data = tx_d;
  assign lnk.l2a_last = tx_last;

  assign ack_fire = ck_ok && ck_type == BCF_MT_FAULT;
  assign go = !busy && !tx_v && ack_pend;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mgmt_bearer_valid_o <= 1'b0;
      mgmt_bearer_primitive_o <= BCF_P_NONE;
      mgmt_ts_o <= 8'h00;
      mgmt_port_o <= 8'h00;
    end else begin
      mgmt_bearer_valid_o <= ack_fire;
      mgmt_bearer_primitive_o <= ack_fire ? BCF_P_FAULT_IND : BCF_P_NONE;
      if (ack_fire) begin
        mgmt_ts_o <= ck_val[BCF_IE_TS[2:0]];
        mgmt_port_o <= ck_val[BCF_IE_PORT[2:0]];
      end
    end
  end

  // Later fault overwrites the waiting reference
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ack_pend <= 1'b0;
      ack_ref <= 16'h0000;
    end else begin
      ack_pend <= ack_fire || (ack_pend && !go);
      if (ack_fire) begin
        ack_ref <= ck_ref;
      end
    end
  end

  always_comb begin
    case (idx)
      2'h0: oct = BCF_PD;
      2'h1: oct = ack_ref[15:8];
      2'h2: oct = ack_ref[7:0];
      default: oct = BCF_MT_FAULT_ACK;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      busy <= 1'b0;
      idx <= 2'h0;
      tx_v <= 1'b0;
      tx_d <= 8'h00;
      tx_last <= 1'b0;
    end else if (busy) begin
      tx_v <= 1'b1;
      tx_d <= oct;
      tx_last <= idx == BCF_ACK_LAST;
      idx <= idx + 2'h1;
      if (idx == BCF_ACK_LAST) begin
        busy <= 1'b0;
      end
    end else begin
      tx_v <= 1'b0;
      tx_last <= 1'b0;
      idx <= 2'h0;
      busy <= go;
    end
  end

endmodule : bcf_le_end

// ==== src/bcf_link_if.sv ====
// Purpose: Octet link joining the access end and the exchange end
// Assumes: Both ends on mclk_i, no back-pressure
// Notes: a2l carries access-to-exchange frames, l2a the reverse
`timescale 1ns/100ps
interface bcf_link_if;
  logic a2l_valid;
  logic [7:0] a2l_data;
  logic a2l_last;
  logic l2a_valid;
  logic [7:0] l2a_data;
  logic l2a_last;

  modport an (
    output a2l_valid, a2l_data, a2l_last,
    input l2a_valid, l2a_data, l2a_last
  );
  modport le (
    input a2l_valid, a2l_data, a2l_last,
    output l2a_valid, l2a_data, l2a_last
  );
endinterface : bcf_link_if

// ==== src/bcf_msg_check.sv ====
// Purpose: Received message validation shared by both ends
// Assumes: At least one idle cycle between the last octet and a new message
// Notes: Verdict appears two cycles after the last octet
`timescale 1ns/100ps
module bcf_msg_check (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Octet stream in
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_last_i,
  // Verdict
  output logic ok_o,
  output logic err_o,
  output logic disc_o,
  output bcf_pkg::bcf_cause_t cause_o,
  output logic [7:0] diag_o,
  output logic [7:0] type_o,
  output logic [15:0] ref_o,
  output logic [7:0][7:0] val_o
);
  import bcf_pkg::*;

  typedef enum logic [1:0] {PH_HDR, PH_ID, PH_LEN, PH_BODY} bcf_phase_t;

  bcf_phase_t phase;
  logic [1:0] hpos;
  logic hdr_done, pd_bad, have_prev, trunc, keep_cur, rep_mand, done;
  logic keep, third;
  logic [7:0] mtype, prev_id, len_rem, cur_diag, fdiag, first_miss;
  logic [7:0] seen, mand, miss;
  logic [15:0] mref;
  logic [1:0] opt_cnt;
  logic [2:0] idx, cur_idx;
  logic disc;
  bcf_cause_t cur_cause, ev, fcause;
  logic [7:0] vals [8];

  assign idx = rx_data_i[2:0];
  assign mand = bcf_mand_mask(mtype);
  assign miss = mand & ~seen;

  // Classify each element identifier as it arrives
  always_comb begin
    ev = BCF_C_NONE;
    keep = 1'b0;
    third = 1'b0;
    if (phase == PH_ID) begin
      if (trunc) begin
        ev = BCF_C_REP_OPT;
      end else if (!bcf_ie_known(rx_data_i)) begin
        ev = BCF_C_UNREC;
      end else if (have_prev && rx_data_i < prev_id) begin
        ev = BCF_C_OOS;
      end else if (seen[idx]) begin
        ev = mand[idx] ? BCF_C_REP_MAND : BCF_C_REP_OPT;
      end else if (!mand[idx] && opt_cnt == BCF_MAX_OPT) begin
        ev = BCF_C_REP_OPT;
        third = 1'b1;
      end else begin
        keep = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    done <= rst_n_i && rx_valid_i && rx_last_i;
  end

  // Scratch parse state; cleared after every verdict so nothing leaks on
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || done) begin
      phase <= PH_HDR;
      hpos <= 2'h0;
      {hdr_done, pd_bad, have_prev, trunc, keep_cur, rep_mand} <= 6'h00;
      {mtype, prev_id, len_rem, cur_diag, seen} <= 40'h0;
      mref <= 16'h0000;
      opt_cnt <= 2'h0;
      cur_idx <= 3'h0;
      cur_cause <= BCF_C_NONE;
      for (int i = 0; i < 8; i++) begin
        vals[i] <= 8'h00;
      end
    end else if (rx_valid_i) begin
      case (phase)
        PH_HDR: begin
          hpos <= hpos + 2'h1;
          case (hpos)
            2'h0: pd_bad <= rx_data_i != BCF_PD;
            2'h1: mref[15:8] <= rx_data_i;
            2'h2: mref[7:0] <= rx_data_i;
            default: begin
              mtype <= rx_data_i;
              hdr_done <= 1'b1;
              phase <= PH_ID;
            end
          endcase
        end
        PH_ID: begin
          if (ev < cur_cause) begin
            cur_cause <= ev;
            cur_diag <= rx_data_i;
          end
          if (ev == BCF_C_REP_MAND) begin
            rep_mand <= 1'b1;
          end
          if (third) begin
            trunc <= 1'b1;
          end
          if (keep) begin
            seen[idx] <= 1'b1;
            prev_id <= rx_data_i;
            have_prev <= 1'b1;
            if (!mand[idx]) begin
              opt_cnt <= opt_cnt + 2'h1;
            end
          end
          keep_cur <= keep;
          cur_idx <= idx;
          phase <= PH_LEN;
        end
        PH_LEN: begin
          len_rem <= rx_data_i;
          phase <= (rx_data_i == 8'h00) ? PH_ID : PH_BODY;
        end
        default: begin
          if (keep_cur) begin
            vals[cur_idx] <= rx_data_i;
          end
          len_rem <= len_rem - 8'h01;
          if (len_rem == 8'h01) begin
            phase <= PH_ID;
          end
        end
      endcase
    end
  end

  // Final verdict in precedence order
  always_comb begin
    first_miss = BCF_IE_BASE;
    for (int i = 7; i >= 0; i--) begin
      if (miss[i]) begin
        first_miss = BCF_IE_BASE | 8'(i);
      end
    end
    fcause = cur_cause;
    fdiag = cur_diag;
    if (!hdr_done) begin
      fcause = BCF_C_SHORT;
      fdiag = 8'h00;
    end else if (pd_bad) begin
      fcause = BCF_C_PD;
      fdiag = 8'h00;
    end else if (!bcf_mt_known(mtype)) begin
      fcause = BCF_C_TYPE;
      fdiag = mtype;
    end else if (miss != 8'h00 && cur_cause > BCF_C_MISS) begin
      fcause = BCF_C_MISS;
      fdiag = first_miss;
    end
    disc = !hdr_done || pd_bad || !bcf_mt_known(mtype) || rep_mand || miss != 8'h00;
  end

  // Results change only at a verdict, bar ok and err falling a cycle later; discarded element values never land
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      {ok_o, err_o, disc_o} <= 3'h0;
      cause_o <= BCF_C_NONE;
      {diag_o, type_o} <= 16'h0000;
      ref_o <= 16'h0000;
      val_o <= '0;
    end else if (done) begin
      ok_o <= !disc;
      err_o <= fcause != BCF_C_NONE;
      disc_o <= disc;
      cause_o <= fcause;
      diag_o <= fdiag;
      type_o <= mtype;
      ref_o <= mref;
      if (!disc) begin
        for (int i = 0; i < 8; i++) begin
          val_o[i] <= vals[i];
        end
      end
    end else begin
      ok_o <= 1'b0;
      err_o <= 1'b0;
    end
  end

endmodule : bcf_msg_check

// ==== src/bcf_pkg.sv ====
// Purpose: Shared constants, types and decoders for the bearer fault link
// Assumes: 10 MHz mclk_i, octet-wide message link between the two ends
// Notes: Message header is discriminator, two reference octets, type
package bcf_pkg;

  // Header layout and limits
  localparam logic [7:0] BCF_PD = 8'h48;
  localparam int BCF_MIN_OCTETS = 4;
  localparam logic [1:0] BCF_MAX_OPT = 2'h2;
  localparam logic [15:0] BCF_REF_RST = 16'h0000;

  // Message types
  localparam logic [7:0] BCF_MT_ALLOC = 8'h20;
  localparam logic [7:0] BCF_MT_DEALLOC = 8'h23;
  localparam logic [7:0] BCF_MT_AUDIT = 8'h26;
  localparam logic [7:0] BCF_MT_FAULT = 8'h28;
  localparam logic [7:0] BCF_MT_FAULT_ACK = 8'h29;
  localparam logic [7:0] BCF_MT_PERR = 8'h2a;

  // Element identifiers, all recognised ones share the upper five bits
  localparam logic [7:0] BCF_IE_BASE = 8'h40;
  localparam logic [7:0] BCF_IE_TS = 8'h41;
  localparam logic [7:0] BCF_IE_PORT = 8'h42;
  localparam logic [7:0] BCF_IE_CAUSE = 8'h43;
  localparam logic [7:0] BCF_IE_DIAG = 8'h44;
  localparam logic [7:0] BCF_IE_LEN1 = 8'h01;
  localparam logic [7:0] BCF_MAND_SLOT = 8'h02;
  localparam logic [7:0] BCF_MAND_CAUSE = 8'h08;

  // Frame lengths sent by the two ends
  localparam logic [3:0] BCF_TX_LEN = 4'ha;
  localparam logic [1:0] BCF_ACK_LAST = 2'h3;

  // Timing
  localparam int BCF_CLK_NS = 100;
  localparam int BCF_TICK_MS = 100;
  localparam int BCF_TICK_CYC = BCF_TICK_MS * 1000000 / BCF_CLK_NS;
  localparam int BCF_T5_MS = 1000;
  localparam int BCF_T5_TICKS = BCF_T5_MS / BCF_TICK_MS;

  // Causes in order of precedence, none last
  typedef enum logic [3:0] {
    BCF_C_SHORT, BCF_C_PD, BCF_C_TYPE, BCF_C_OOS, BCF_C_REP_MAND,
    BCF_C_REP_OPT, BCF_C_MISS, BCF_C_UNREC, BCF_C_NONE
  } bcf_cause_t;

  typedef enum logic [1:0] {
    BCF_P_NONE, BCF_P_FAULT_CFM, BCF_P_FAULT_ERR, BCF_P_FAULT_IND
  } bcf_prim_t;

  function automatic logic bcf_mt_known(input logic [7:0] t);
    return (t >= BCF_MT_ALLOC) && (t <= BCF_MT_PERR);
  endfunction : bcf_mt_known

  function automatic logic bcf_ie_known(input logic [7:0] id);
    return id[7:3] == BCF_IE_BASE[7:3];
  endfunction : bcf_ie_known

  function automatic logic [7:0] bcf_mand_mask(input logic [7:0] t);
    case (t)
      BCF_MT_ALLOC, BCF_MT_DEALLOC, BCF_MT_AUDIT: return BCF_MAND_SLOT;
      BCF_MT_PERR: return BCF_MAND_CAUSE;
      default: return 8'h00;
    endcase
  endfunction : bcf_mand_mask

endpackage : bcf_pkg

// ==== testbench/bcf_link_checker.sv ====
// Purpose: Wire checks on the main access-exchange link
// Assumes: Both ends on mclk_i
// Notes: Only the design-to-design link is watched
`timescale 1ns/100ps
module bcf_link_checker
  import bcf_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Link signals
  input wire logic a2l_valid,
  input wire logic [7:0] a2l_data,
  input wire logic a2l_last,
  input wire logic l2a_valid,
  input wire logic [7:0] l2a_data,
  input wire logic l2a_last
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_A_LEN: assert property ($rose(a2l_valid) |->
    (a2l_valid && !a2l_last) [*8] ##1 (a2l_valid && !a2l_last) ##1 (a2l_valid && a2l_last))
    else $error("a2l length");
  AST_A_PD: assert property ($rose(a2l_valid) |-> a2l_data == BCF_PD)
    else $error("a2l header");
  AST_A_GAP: assert property (a2l_last |=> !a2l_valid)
    else $error("a2l gap");
  AST_A_BODY: assert property ($rose(a2l_valid) ##3 (a2l_data == BCF_MT_FAULT) |=>
    a2l_data == BCF_IE_TS ##1 a2l_data == BCF_IE_LEN1 ##2 a2l_data == BCF_IE_PORT)
    else $error("fault body");
  AST_L_LEN: assert property ($rose(l2a_valid) |->
    (l2a_valid && !l2a_last) [*3] ##1 (l2a_valid && l2a_last)) else $error("l2a length");
  AST_L_PD: assert property ($rose(l2a_valid) |-> l2a_data == BCF_PD)
    else $error("l2a header");
  AST_L_TYPE: assert property (l2a_last |-> l2a_data == BCF_MT_FAULT_ACK)
    else $error("l2a type");
  AST_L_GAP: assert property (l2a_last |=> !l2a_valid)
    else $error("l2a gap");
  AST_ACK: assert property ($rose(a2l_valid) ##3 (a2l_data == BCF_MT_FAULT) ##6 a2l_last
    |-> ##[3:12] $rose(l2a_valid)) else $error("no acknowledge");

  cover property ($rose(a2l_valid));
  cover property (l2a_last);
  cover property (a2l_last ##[1:20] l2a_last);
endmodule : bcf_link_checker

// ==== testbench/test_bearer_ctrl_fault_and_msg_check.sv ====
// Purpose: Bench for both link ends and the message checks
// Assumes: Short timer parameters, one clock
// Notes: Second access end faces the bench, which forges frames
`timescale 1ns/100ps
module test_bearer_ctrl_fault_and_msg_check;
  import bcf_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req1 = 1'b0;
  logic req2 = 1'b0;
  logic [7:0] ts = 8'h05;
  logic [7:0] port = 8'h09;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int nfr = 0;
  int ncap = 0;
  logic [7:0] cap [10];
  logic v1, v2, vle, act1, ok2, pe2, pe1, pel, act2;
  bcf_prim_t p1, p2, ple;
  bcf_cause_t c2;
  logic [7:0] d2, lts, lport, atype, ltype;
  logic [15:0] lref, r2;

  bcf_link_if lnk ();
  bcf_link_if lnk2 ();
  // Long timer here so the acknowledge wins the race
  bcf_an_end #(.TICK_CYC(4), .T5_TICKS(10)) u_bcf_an_end (.mclk_i, .rst_n_i,
    .lnk(lnk.an), .flt_req_i(req1), .flt_ts_i(ts), .flt_port_i(port),
    .mgmt_bearer_valid_o(v1), .mgmt_bearer_primitive_o(p1), .flt_active_o(act1),
    .perr_o(pe1), .perr_cause_o(), .perr_diag_o(), .rx_ok_o(), .rx_type_o(atype), .rx_ref_o());
  bcf_le_end u_bcf_le_end (.mclk_i, .rst_n_i, .lnk(lnk.le), .mgmt_bearer_valid_o(vle),
    .mgmt_bearer_primitive_o(ple), .mgmt_ts_o(lts), .mgmt_port_o(lport), .perr_o(pel),
    .perr_cause_o(), .perr_diag_o(), .rx_ok_o(), .rx_type_o(ltype), .rx_ref_o(lref));
  bcf_an_end #(.TICK_CYC(4), .T5_TICKS(3)) u_bcf_an_end_b (.mclk_i, .rst_n_i,
    .lnk(lnk2.an), .flt_req_i(req2), .flt_ts_i(ts), .flt_port_i(port),
    .mgmt_bearer_valid_o(v2), .mgmt_bearer_primitive_o(p2), .flt_active_o(act2),
    .perr_o(pe2), .perr_cause_o(c2), .perr_diag_o(d2), .rx_ok_o(ok2), .rx_type_o(),
    .rx_ref_o(r2));
  bcf_link_checker u_bcf_link_checker (.mclk_i, .rst_n_i, .a2l_valid(lnk.a2l_valid),
    .a2l_data(lnk.a2l_data), .a2l_last(lnk.a2l_last), .l2a_valid(lnk.l2a_valid),
    .l2a_data(lnk.l2a_data), .l2a_last(lnk.l2a_last));

  initial begin
    forever #50 mclk_i = ~mclk_i;
  end

  // Frames sent by the second access end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
    if (lnk2.a2l_valid) begin
      if (ncap < 10) cap[ncap] = lnk2.a2l_data;
      ncap = lnk2.a2l_last ? 0 : ncap + 1;
      if (lnk2.a2l_last) nfr++;
    end
  end

  task automatic give_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic send(input logic [7:0] q[$]);
    @(posedge mclk_i);
    foreach (q[i]) begin
      lnk2.l2a_valid <= 1'b1;
      lnk2.l2a_data <= q[i];
      lnk2.l2a_last <= (i == q.size() - 1);
      @(posedge mclk_i);
    end
    lnk2.l2a_valid <= 1'b0;
    lnk2.l2a_last <= 1'b0;
    lnk2.l2a_data <= ~q[q.size() - 1];
  endtask : send

  // One forged frame, verdict and any error frame sent back
  task automatic msg(input logic [7:0] q[$], input bcf_cause_t ec, input logic [7:0] ed,
      input logic eo);
    int n0;
    logic oks;
    logic ers;
    logic rep;
    oks = 1'b0;
    ers = 1'b0;
    rep = (ec != BCF_C_NONE) && (ec != BCF_C_SHORT);
    send(q);
    n0 = nfr;
    repeat (4) begin
      @(posedge mclk_i);
      #1;
      oks |= ok2;
      ers |= pe2;
    end
    chk(oks, eo);
    chk(ers, ec != BCF_C_NONE);
    chk(c2, ec);
    if (ec != BCF_C_NONE) chk(d2, ed);
    for (int i = 0; i < 40 && nfr == n0; i++) @(posedge mclk_i);
    chk(nfr - n0, rep);
    if (rep) begin
      chk(cap[3], BCF_MT_PERR);
      chk({cap[1], cap[2]}, 16'h0007);
      chk(cap[6], ec);
      chk(cap[9], ed);
    end
  endtask : msg

  task automatic t_ack();
    logic ind;
    logic cfm;
    logic bad;
    ind = 1'b0;
    cfm = 1'b0;
    bad = 1'b0;
    req1 <= 1'b1;
    @(posedge mclk_i);
    req1 <= 1'b0;
    repeat (60) begin
      @(posedge mclk_i);
      #1;
      bad |= pe1 | pel;
      if (vle) begin
        ind = 1'b1;
        chk(ple, BCF_P_FAULT_IND);
        chk({lts, lport}, {ts, port});
      end
      if (v1) begin
        cfm = 1'b1;
        chk(p1, BCF_P_FAULT_CFM);
      end
    end
    chk({ind, cfm, act1}, 3'h6);
    chk(lref, 16'h0001);
    chk(bad, 1'b0);
    chk({atype, ltype}, {BCF_MT_FAULT_ACK, BCF_MT_FAULT});
  endtask : t_ack

  task automatic t_expiry();
    int n0;
    int at;
    logic err;
    n0 = nfr;
    at = 0;
    err = 1'b0;
    @(posedge mclk_i);
    req2 <= 1'b1;
    @(posedge mclk_i);
    req2 <= 1'b0;
    for (int k = 1; k <= 150; k++) begin
      @(posedge mclk_i);
      #1;
      if (k == 1) chk(act2, 1'b1);
      if (v2) begin
        err = 1'b1;
        at = k;
        chk(p2, BCF_P_FAULT_ERR);
      end
    end
    chk(err, 1'b1);
    // Two full timer periods of three 4-cycle ticks each
    chk(at, 2 * 3 * 4);
    chk(act2, 1'b0);
    chk(nfr - n0, 2);
    chk(cap[3], BCF_MT_FAULT);
    chk({cap[1], cap[2]}, 16'h0001);
  endtask : t_expiry

  initial begin
    lnk2.l2a_valid = 1'b0;
    lnk2.l2a_data = 8'h00;
    lnk2.l2a_last = 1'b0;
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_ack();
    t_expiry();
    msg({8'h48, 8'h00, 8'h07}, BCF_C_SHORT, 8'h00, 1'b0);
    msg({8'h47, 8'h00, 8'h07, 8'h30}, BCF_C_PD, 8'h00, 1'b0);
    msg({8'h48, 8'h00, 8'h07, 8'h30}, BCF_C_TYPE, 8'h30, 1'b0);
    msg({8'h48, 8'h00, 8'h07, 8'h29, 8'h42, 8'h01, 8'h00, 8'h41, 8'h01, 8'h00},
      BCF_C_OOS, 8'h41, 1'b1);
    msg({8'h48, 8'h00, 8'h07, 8'h20, 8'h42, 8'h01, 8'h00, 8'h41, 8'h01, 8'h00},
      BCF_C_OOS, 8'h41, 1'b0);
    msg({8'h48, 8'h00, 8'h07, 8'h20, 8'h41, 8'h01, 8'h00, 8'h41, 8'h01, 8'h00},
      BCF_C_REP_MAND, 8'h41, 1'b0);
    msg({8'h48, 8'h00, 8'h07, 8'h29, 8'h42, 8'h01, 8'h00, 8'h42, 8'h01, 8'h00},
      BCF_C_REP_OPT, 8'h42, 1'b1);
    msg({8'h48, 8'h00, 8'h07, 8'h29, 8'h42, 8'h01, 8'h00, 8'h43, 8'h01, 8'h00, 8'h44,
      8'h01, 8'h00}, BCF_C_REP_OPT, 8'h44, 1'b1);
    msg({8'h48, 8'h00, 8'h07, 8'h20}, BCF_C_MISS, 8'h41, 1'b0);
    msg({8'h48, 8'h00, 8'h07, 8'h29, 8'h50, 8'h01, 8'h00, 8'h51, 8'h01, 8'h00},
      BCF_C_UNREC, 8'h50, 1'b1);
    msg({8'h48, 8'h00, 8'h07, 8'h29}, BCF_C_NONE, 8'h00, 1'b1);
    chk(r2, 16'h0007);
    give_verdict();
  end
endmodule : test_bearer_ctrl_fault_and_msg_check
